// ==== common/bridge_ctrl_pkg.sv ====
package bridge_ctrl_pkg;

    // Wake-up settle time after the low-power request is released
    localparam int WAKE_TIME_US = 1000;
    localparam int CLK_MHZ = 20;
    localparam int WAKE_CYCLES = WAKE_TIME_US * CLK_MHZ;
    // Overcurrent qualification time; value not given, plain default
    localparam int OC_QUAL_TIME_NS = 3000;
    localparam int CLK_PERIOD_NS = 50;
    localparam int OC_QUAL_CYCLES =
        (OC_QUAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FET_COUNT = 4;

    localparam logic [3:0] FET_LIMIT_RST = 4'h0;

    typedef enum logic [1:0] {
        ST_OFF,
        ST_WAKE,
        ST_RUN,
        ST_LATCHED
    } op_state_t;

    typedef struct packed {
        logic bridge_en;
        logic charge_pump_en;
        logic aux_regulator_output_en;
        logic clocks_en;
    } power_ctl_t;

endpackage

// ==== logic/motor_bridge_fault_power_ctrl.sv ====
// Operation
// - Clear low resets all logic and holds the bridge disabled.
// - While clear is low, all other control inputs are ignored.
// - Low-power request low stops bridge, charge pump, regulator, clocks.
// - In low power, all control inputs but clear are ignored until the request rises.
// - About 1 ms after wake before normal driving; host waits.
// - Current limit beyond qualification time: bridge off, fault low.
// - Overcurrent shutdown latches until clear pulse or supply cycle.
// - Detection covers high-side and low-side transistors.
// - Detection is independent of the chopping sense path.
// - Over-temperature: bridge off, fault low, resumes automatically.
// - Supply below lockout: everything off and logic reset.
`timescale 1ns/100ps
`default_nettype none
module motor_bridge_fault_power_ctrl
    import bridge_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_RST_N,
    // Host control pins
    input wire logic I_CHIP_CLEAR_N,
    input wire logic I_LOW_POWER_REQUEST_N,
    input wire logic I_IN1,
    input wire logic I_IN2,
    // Analog monitors, one limit flag per FET
    input wire logic [FET_COUNT-1:0] I_FET_LIMIT,
    input wire logic I_THERMAL_TRIP,
    input wire logic I_SUPPLY_LOW_LOCKOUT,
    // Power and bridge control
    output logic O_BRIDGE_EN,
    output logic O_CHARGE_PUMP_EN,
    output logic O_AUX_REGULATOR_OUTPUT_EN,
    output logic O_CLOCKS_EN,
    output logic O_IN1,
    output logic O_IN2,
    output logic O_READY,
    // Open-drain fault flag
    output logic O_FAULT_FLAG_N_O,
    output logic O_FAULT_FLAG_N_OE_N
);

    logic clear_n_s, sleep_n_s, thermal_s, supply_low_lockout_s, in1_s, in2_s;
    logic [FET_COUNT-1:0] limit_s;

    sync2 u_clr (.clk(I_CLK), .d(I_CHIP_CLEAR_N), .q(clear_n_s));
    sync2 u_slp (.clk(I_CLK), .d(I_LOW_POWER_REQUEST_N), .q(sleep_n_s));
    sync2 u_tsd (.clk(I_CLK), .d(I_THERMAL_TRIP), .q(thermal_s));
    sync2 u_uv (.clk(I_CLK), .d(I_SUPPLY_LOW_LOCKOUT), .q(supply_low_lockout_s));
    sync2 u_i1 (.clk(I_CLK), .d(I_IN1), .q(in1_s));
    sync2 u_i2 (.clk(I_CLK), .d(I_IN2), .q(in2_s));

    genvar g;
    generate
        for (g = 0; g < FET_COUNT; g++) begin : g_lim
            sync2 u_l (.clk(I_CLK), .d(I_FET_LIMIT[g]), .q(limit_s[g]));
        end
    endgenerate

    op_state_t state_r, state_nxt;
    logic [14:0] wake_cnt_r, wake_cnt_nxt;
    logic [7:0] oc_cnt_r, oc_cnt_nxt;
    power_ctl_t pwr_r, pwr_nxt;
    logic fault_nxt;
    logic in1_r, in1_nxt, in2_r, in2_nxt, ready_r, ready_nxt;
    logic hold_reset, any_limit, oc_hit, awake;

    // Clear, lockout and chip reset all force the initial state
    assign hold_reset = !I_RST_N || !clear_n_s || supply_low_lockout_s;
    assign any_limit = |limit_s;
    assign oc_hit = any_limit && (oc_cnt_r == 8'(OC_QUAL_CYCLES - 1));

    always_comb begin
        state_nxt = state_r;
        wake_cnt_nxt = wake_cnt_r;
        oc_cnt_nxt = 8'h00;
        case (state_r)
            ST_OFF: begin
                if (sleep_n_s) begin
                    state_nxt = ST_WAKE;
                    wake_cnt_nxt = 15'h0000;
                end
            end
            ST_WAKE: begin
                wake_cnt_nxt = wake_cnt_r + 15'h0001;
                if (wake_cnt_r == 15'(WAKE_CYCLES - 1)) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                if (any_limit) begin
                    oc_cnt_nxt = oc_cnt_r + 8'h01;
                end
                if (oc_hit) begin
                    state_nxt = ST_LATCHED;
                end
            end
            ST_LATCHED: begin
                state_nxt = ST_LATCHED;
            end
        endcase
        // Sleep overrides all but reset; an overcurrent latch survives it
        if (!sleep_n_s) begin
            if (state_r == ST_LATCHED) begin
                state_nxt = ST_LATCHED;
            end else begin
                state_nxt = ST_OFF;
            end
            wake_cnt_nxt = 15'h0000;
            oc_cnt_nxt = 8'h00;
        end
        if (hold_reset) begin
            state_nxt = ST_OFF;
            wake_cnt_nxt = 15'h0000;
            oc_cnt_nxt = 8'h00;
        end
    end

    always_comb begin
        // Power stays off in sleep, also while an overcurrent is latched
        awake = (state_nxt != ST_OFF) && sleep_n_s && !hold_reset;
        pwr_nxt.clocks_en = awake;
        pwr_nxt.charge_pump_en = awake;
        pwr_nxt.aux_regulator_output_en = awake;
        pwr_nxt.bridge_en = (state_nxt == ST_RUN) && !thermal_s;
        ready_nxt = (state_nxt == ST_RUN);
        // Steering passes only when the bridge may drive
        in1_nxt = pwr_nxt.bridge_en && in1_s;
        in2_nxt = pwr_nxt.bridge_en && in2_s;
        // Flag follows latch and temperature; releases when both clear
        fault_nxt = (state_nxt == ST_LATCHED) ||
                    (thermal_s && !hold_reset);
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            state_r <= ST_OFF;
            wake_cnt_r <= 15'h0000;
            oc_cnt_r <= 8'h00;
            pwr_r <= '0;
            in1_r <= 1'b0;
            in2_r <= 1'b0;
            ready_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            wake_cnt_r <= wake_cnt_nxt;
            oc_cnt_r <= oc_cnt_nxt;
            pwr_r <= pwr_nxt;
            in1_r <= in1_nxt;
            in2_r <= in2_nxt;
            ready_r <= ready_nxt;
        end
    end

    // Outputs read their own registers, loaded from the next-state decode
    assign O_BRIDGE_EN = pwr_r.bridge_en;
    assign O_CHARGE_PUMP_EN = pwr_r.charge_pump_en;
    assign O_AUX_REGULATOR_OUTPUT_EN = pwr_r.aux_regulator_output_en;
    assign O_CLOCKS_EN = pwr_r.clocks_en;
    assign O_IN1 = in1_r;
    assign O_IN2 = in2_r;
    assign O_READY = ready_r;

    // Fault pin flops; the flag state lives in the enable flop itself
    always_ff @(posedge I_CLK) begin
        O_FAULT_FLAG_N_O <= 1'b0;
        // Enable low means pulling the line low
        O_FAULT_FLAG_N_OE_N <= !(I_RST_N && fault_nxt);
    end

endmodule
`default_nettype wire

// ==== logic/sync2.sv ====
`timescale 1ns/100ps
`default_nettype none
module sync2 (
    input wire logic clk,
    input wire logic d,
    output logic q
);
    logic meta_r;
    always_ff @(posedge clk) begin
        meta_r <= d;
        q <= meta_r;
    end
endmodule
`default_nettype wire

// ==== tb/bridge_chk_assertions.sv ====
`timescale 1ns/100ps
`default_nettype none
module bridge_chk (
    // Pins and monitors
    input wire logic I_CLK, I_RST_N, I_CHIP_CLEAR_N,
    input wire logic I_LOW_POWER_REQUEST_N, I_THERMAL_TRIP,
    input wire logic I_SUPPLY_LOW_LOCKOUT,
    input wire logic [3:0] I_FET_LIMIT,
    // Outputs
    input wire logic O_BRIDGE_EN, O_CHARGE_PUMP_EN, O_CLOCKS_EN,
    input wire logic O_AUX_REGULATOR_OUTPUT_EN, O_IN1, O_IN2,
    input wire logic O_READY, O_FAULT_FLAG_N_OE_N
);
    int oc_r;
    int wk_r;
    wire ok = I_CHIP_CLEAR_N && I_LOW_POWER_REQUEST_N &&
        !I_SUPPLY_LOW_LOCKOUT;
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);
    // Limit run length while driving, and cycles with clocks on
    always_ff @(posedge I_CLK) begin
        oc_r <= (ok && !I_THERMAL_TRIP && |I_FET_LIMIT &&
            (O_BRIDGE_EN || oc_r > 0)) ? oc_r + 1 : 0;
        wk_r <= O_CLOCKS_EN ? wk_r + 1 : 0;
    end
    chk_clear_off: assert property (!I_CHIP_CLEAR_N [*4] |->
        !O_BRIDGE_EN && !O_IN1 && !O_IN2 && O_FAULT_FLAG_N_OE_N)
        else $error("bridge on while cleared");
    chk_sleep_off: assert property (!I_LOW_POWER_REQUEST_N [*4] |->
        !(O_BRIDGE_EN || O_CLOCKS_EN || O_CHARGE_PUMP_EN ||
        O_AUX_REGULATOR_OUTPUT_EN)) else $error("awake in sleep");
    chk_lockout_off: assert property (I_SUPPLY_LOW_LOCKOUT [*4] |->
        !O_CLOCKS_EN && !O_BRIDGE_EN) else $error("on in lockout");
    chk_oc_early: assert property (oc_r == 50 |-> O_BRIDGE_EN)
        else $error("overcurrent trip too early");
    chk_oc_trip: assert property (oc_r == 66 |->
        !O_BRIDGE_EN && !O_FAULT_FLAG_N_OE_N) else $error("no trip");
    chk_oc_latch: assert property ((ok && !I_THERMAL_TRIP) [*6]
        ##0 !O_FAULT_FLAG_N_OE_N |=> !O_FAULT_FLAG_N_OE_N)
        else $error("latch lost");
    chk_therm_trip: assert property ((ok && I_THERMAL_TRIP) [*4] |->
        !O_BRIDGE_EN && !O_FAULT_FLAG_N_OE_N) else $error("no hot stop");
    chk_wake_time: assert property ($rose(O_READY) |-> wk_r > 19990)
        else $error("ready too soon");
endmodule
bind motor_bridge_fault_power_ctrl bridge_chk i_chk (.*);
`default_nettype wire

// ==== tb/host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module host_model (
    // Clock and fault line
    input wire logic clk,
    input wire logic fault_n,
    // Control pins
    output logic clear_n,
    output logic sleep_n,
    output logic [1:0] steer
);
    initial {clear_n, sleep_n, steer} = 4'h0;
    task automatic pins(input logic c, s, input logic [1:0] d);
        @(negedge clk);
        clear_n = c;
        sleep_n = s;
        steer = d;
    endtask
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic clk = 0, rst_n = 0, hot = 0, lock = 0;
    logic [3:0] lim = 4'h0;
    logic ce, lp, oe_n, fo, br, cp, ax, ck, o1, o2, rdy;
    logic [1:0] st;
    wire fault_n = oe_n ? 1'b1 : fo;
    int err_total = 0, n_compared = 0;
    `define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin \
        err_total++; $display("BAD %0t %h %h", $time, a, e); end end
    always #25 clk = ~clk;
    host_model i_host (.clk(clk), .fault_n(fault_n), .clear_n(ce),
        .sleep_n(lp), .steer(st));
    motor_bridge_fault_power_ctrl i_dut (.I_CLK(clk), .I_RST_N(rst_n),
        .I_CHIP_CLEAR_N(ce), .I_LOW_POWER_REQUEST_N(lp), .I_IN1(st[1]),
        .I_IN2(st[0]), .I_FET_LIMIT(lim), .I_THERMAL_TRIP(hot),
        .I_SUPPLY_LOW_LOCKOUT(lock), .O_BRIDGE_EN(br), .O_CHARGE_PUMP_EN(cp),
        .O_AUX_REGULATOR_OUTPUT_EN(ax), .O_CLOCKS_EN(ck), .O_IN1(o1),
        .O_IN2(o2), .O_READY(rdy), .O_FAULT_FLAG_N_O(fo),
        .O_FAULT_FLAG_N_OE_N(oe_n));
    task automatic conclude;
        $display("compared %0d bad %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wake_up;
        int n;
        n = 0;
        while (rdy !== 1'b1 && n < 21000) begin
            cyc(1);
            n++;
        end
        `CHK(n > 19990 && n < 20010, 1'b1)
        if (n == 21000)
            conclude();
        cyc(4);
    endtask
    task automatic s_run;
        i_host.pins(1, 1, 2'b10);
        wake_up();
        `CHK({br, ck, cp, ax, o1, o2, fault_n}, 7'h7D)
        hot = 1;
        cyc(4);
        `CHK({br, fault_n, o1}, 3'h0)
        hot = 0;
        cyc(4);
        `CHK({br, fault_n, o1}, 3'h7)
    endtask
    task automatic s_oc(input int b);
        lim[b] = 1;
        cyc(30);
        lim = 4'h0;
        cyc(4);
        `CHK(br, 1'b1)
        lim[b] = 1;
        cyc(70);
        lim = 4'h0;
        cyc(100);
        `CHK({br, fault_n}, 2'h0)
        i_host.pins(0, 1, 2'b11);
        cyc(4);
        `CHK({br, o1, o2, fault_n}, 4'h1)
        i_host.pins(1, 1, 2'b01);
        wake_up();
        `CHK({o1, o2}, 2'h1)
    endtask
    task automatic s_sleep;
        i_host.pins(1, 0, 2'b10);
        cyc(4);
        `CHK({br, ck, cp, ax, o1}, 5'h0)
        i_host.pins(1, 1, 2'b10);
        wake_up();
        `CHK(o1, 1'b1)
        lock = 1;
        cyc(4);
        `CHK({br, ck, cp, ax, rdy}, 5'h0)
    endtask
    initial begin
        cyc(16);
        rst_n = 1;
        s_run();
        s_oc(0);
        s_oc(3);
        s_sleep();
        conclude();
    end
endmodule
`default_nettype wire
